// *** logic/tasq_sequencer.sv ***
// Converter sequencer: clocking, command shifting, result capture, irq pin.
// Assumes all jumper and connector inputs are asynchronous board pins.
`timescale 1ns/1ps
`include "tasq_map.svh"
module tasq_sequencer
    import tasq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ext_clock_in,
    input wire logic clock_source_jumper,
    input wire logic divider_jumper,
    input wire logic frame_length_jumper_a,
    input wire logic frame_length_jumper_b,
    input wire logic [`TASQ_CMD_BITS-1:0] command_bit_jumpers,
    input wire logic [`TASQ_CMD_BITS-1:0] command_drive_enable,
    input wire logic [`TASQ_CMD_BITS-1:0] command_drive_value,
    input wire logic irq_level_jumper,
    input wire logic irq_pass_jumper,
    input wire logic irq_invert_jumper,
    input wire logic irq_line_in,
    input wire logic irq_line_driven,
    input wire logic converter_dout,
    output logic converter_clock,
    output logic converter_cs_n,
    output logic converter_din,
    output logic touch_irq_pin,
    output logic [`TASQ_WORD_BITS-1:0] parallel_word,
    output logic word_valid_strobe
);

    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'h0;
            rst_n_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Two-stage synchronisers for every board pin
    logic [`TASQ_PIN_BITS-1:0] pin_w;
    logic [`TASQ_PIN_BITS-1:0] pin_meta_q;
    logic [`TASQ_PIN_BITS-1:0] pin_q;

    assign pin_w = {ext_clock_in, clock_source_jumper, divider_jumper,
                    frame_length_jumper_a, frame_length_jumper_b,
                    command_bit_jumpers, command_drive_enable,
                    command_drive_value, irq_level_jumper,
                    irq_pass_jumper, irq_invert_jumper, irq_line_in,
                    irq_line_driven, converter_dout};

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_meta_q <= '0;
            pin_q <= '0;
        end else begin
            pin_meta_q <= pin_w;
            pin_q <= pin_meta_q;
        end
    end

    logic ext_clk_w;
    logic src_osc_w;
    logic div_slow_w;
    logic len_a_w;
    logic len_b_w;
    logic [`TASQ_CMD_BITS-1:0] cmd_jump_w;
    logic [`TASQ_CMD_BITS-1:0] cmd_en_w;
    logic [`TASQ_CMD_BITS-1:0] cmd_val_w;
    logic irq_lvl_w;
    logic irq_pass_w;
    logic irq_inv_w;
    logic irq_line_w;
    logic irq_drv_w;
    logic dout_w;

    assign {ext_clk_w, src_osc_w, div_slow_w, len_a_w, len_b_w,
            cmd_jump_w, cmd_en_w, cmd_val_w, irq_lvl_w, irq_pass_w,
            irq_inv_w, irq_line_w, irq_drv_w, dout_w} = pin_q;

    // Converter clock source and divider
    tasq_count_type half_w;
    logic div_tick_w;
    logic conv_d;

    assign half_w = div_slow_w ? 5'(`TASQ_DIV_SLOW / 2) :
                                 5'(`TASQ_DIV_FAST / 2);

    tasq_clock_divider u_divider (
        .clk(clk),
        .rst_n(rst_n_q),
        .half_count(half_w),
        .tick(div_tick_w)
    );

    assign conv_d = src_osc_w ?
                    (div_tick_w ? ~converter_clock : converter_clock) :
                    ext_clk_w;

    logic rise_w;
    logic fall_w;

    assign rise_w = conv_d & ~converter_clock;
    assign fall_w = ~conv_d & converter_clock;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            converter_clock <= 1'h0;
        end else begin
            converter_clock <= conv_d;
        end
    end

    // Frame sequencing
    tasq_state_type state_q;
    tasq_state_type state_d;
    tasq_count_type period_q;
    tasq_count_type period_d;
    tasq_count_type last_w;
    logic run_w;
    logic wrap_w;

    assign last_w = (!len_a_w && len_b_w) ?
                    5'(`TASQ_FRAME_LONG - 1) :
                    5'(`TASQ_FRAME_SHORT - 1);
    assign run_w = (state_q == TASQ_RUN);
    assign state_d = (run_w || fall_w) ? TASQ_RUN : TASQ_IDLE;
    assign wrap_w = (period_q >= last_w);
    assign period_d = !(rise_w && run_w) ? period_q :
                      wrap_w ? 5'h00 : period_q + 5'h01;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= TASQ_IDLE;
            period_q <= 5'h00;
            converter_cs_n <= 1'h1;
        end else begin
            state_q <= state_d;
            period_q <= period_d;
            converter_cs_n <= (state_d != TASQ_RUN);
        end
    end

    // Command byte: driven lines win over jumpers
    logic [`TASQ_CMD_BITS-1:0] cmd_word_w;
    logic [`TASQ_CMD_BITS-1:0] cmd_par_w;
    logic cmd_load_w;
    logic cmd_shift_w;

    assign cmd_word_w = (cmd_en_w & cmd_val_w) |
                        (~cmd_en_w & cmd_jump_w);
    assign cmd_load_w = fall_w && (period_q == 5'h00);
    assign cmd_shift_w = fall_w && run_w && (period_q != 5'h00) &&
                         (period_q <= 5'(`TASQ_BUSY_PERIOD));

    tasq_shift_register #(
        .WIDTH(`TASQ_CMD_BITS)
    ) u_command_shifter (
        .clk(clk),
        .rst_n(rst_n_q),
        .load(cmd_load_w),
        .shift(cmd_shift_w),
        .serial_in(1'h0),
        .par_in(cmd_word_w),
        .par_out(cmd_par_w)
    );

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            converter_din <= 1'h0;
        end else begin
            converter_din <= cmd_par_w[`TASQ_CMD_BITS-1];
        end
    end

    // Result capture, MSB first from the converter
    logic [3:0] bits_left_q;
    logic [3:0] bits_left_d;
    logic arm_w;
    logic take_w;
    logic done_q;
    logic [`TASQ_WORD_BITS-1:0] res_par_w;

    assign arm_w = rise_w && run_w &&
                   (period_q == 5'(`TASQ_BUSY_PERIOD));
    assign take_w = rise_w && (bits_left_q != 4'h0);
    assign bits_left_d = arm_w ? 4'(`TASQ_WORD_BITS) :
                         take_w ? bits_left_q - 4'h1 : bits_left_q;

    tasq_shift_register #(
        .WIDTH(`TASQ_WORD_BITS)
    ) u_result_shifter (
        .clk(clk),
        .rst_n(rst_n_q),
        .load(1'h0),
        .shift(take_w && !arm_w),
        .serial_in(dout_w),
        .par_in('0),
        .par_out(res_par_w)
    );

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bits_left_q <= 4'h0;
            done_q <= 1'h0;
        end else begin
            bits_left_q <= bits_left_d;
            done_q <= take_w && !arm_w && (bits_left_q == 4'h1);
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            parallel_word <= '0;
            word_valid_strobe <= 1'h0;
        end else begin
            if (done_q) begin
                parallel_word <= res_par_w;
            end
            word_valid_strobe <= done_q;
        end
    end

    // Pen interrupt strapping
    logic irq_d;

    assign irq_d = (irq_pass_w && irq_drv_w) ? irq_line_w :
                   (irq_inv_w && irq_drv_w) ? ~irq_line_w :
                   ~irq_lvl_w;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            touch_irq_pin <= 1'h1;
        end else begin
            touch_irq_pin <= irq_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_q);

    a_select_spans_run: assert property (
        run_w |=> !converter_cs_n)
        else $error("select not low during frame");

    a_div_ten_period: assert property (
        $rose(converter_clock) && src_osc_w && !div_slow_w |->
        ##10 ($rose(converter_clock) || !src_osc_w || div_slow_w))
        else $error("oscillator divide by ten period wrong");

    a_div_twenty_period: assert property (
        $rose(converter_clock) && src_osc_w && div_slow_w |->
        ##20 ($rose(converter_clock) || !src_osc_w || !div_slow_w))
        else $error("oscillator divide by twenty period wrong");

    a_ext_clock_follow: assert property (
        !src_osc_w ##1 !src_osc_w |-> converter_clock == $past(ext_clk_w))
        else $error("external clock not passed through");

    a_frame_wrap_len: assert property (
        rise_w && run_w && wrap_w |=> period_q == 5'h00)
        else $error("frame did not wrap at its length");

    a_frame_bound: assert property (
        rise_w && run_w && (period_q > last_w) |=> period_q == 5'h00)
        else $error("period beyond frame length");

    a_cmd_first_bit: assert property (
        cmd_load_w |=> ##1 converter_din == $past(cmd_word_w[7], 2))
        else $error("command top bit not driven at load");

    a_cmd_tail_zero: assert property (
        rise_w && run_w && (period_q > 5'(`TASQ_BUSY_PERIOD)) |->
        !converter_din)
        else $error("command line active after eight bits");

    a_word_with_valid: assert property (
        word_valid_strobe |-> parallel_word == $past(res_par_w))
        else $error("parallel word not loaded with strobe");

    a_valid_one_cycle: assert property (
        word_valid_strobe |=> !word_valid_strobe)
        else $error("valid strobe longer than one cycle");

    a_irq_default_high: assert property (
        !irq_lvl_w && !irq_pass_w && !irq_inv_w |=> touch_irq_pin)
        else $error("irq pin not high without options");

    a_irq_float_high: assert property (
        !irq_lvl_w && !irq_drv_w |=> touch_irq_pin)
        else $error("irq pin not high with line undriven");

    a_irq_level_low: assert property (
        irq_lvl_w && !(irq_drv_w && (irq_pass_w || irq_inv_w)) |=>
        !touch_irq_pin)
        else $error("irq pin not low with level option");

    a_irq_pass_line: assert property (
        irq_pass_w && irq_drv_w |=> touch_irq_pin == $past(irq_line_w))
        else $error("irq pin does not follow line");

    a_irq_invert_line: assert property (
        !irq_pass_w && irq_inv_w && irq_drv_w |=>
        touch_irq_pin == !$past(irq_line_w))
        else $error("irq pin does not invert line");

endmodule

// *** logic/tasq_map.svh ***
// Constants of the touch converter evaluation sequencer.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TASQ_MAP_SVH
`define TASQ_MAP_SVH

`define TASQ_CMD_BITS 8
`define TASQ_WORD_BITS 12
`define TASQ_DIV_FAST 10
`define TASQ_DIV_SLOW 20
`define TASQ_FRAME_SHORT 16
`define TASQ_FRAME_LONG 24
`define TASQ_BUSY_PERIOD 8
`define TASQ_CMD_DEFAULT 8'h97
`define TASQ_PIN_BITS 35

`endif

// *** logic/tasq_pkg.sv ***
// Types shared by the touch converter evaluation sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package tasq_pkg;

    typedef enum logic [0:0] {
        TASQ_IDLE = 1'h0,
        TASQ_RUN = 1'h1
    } tasq_state_type;

    typedef logic [4:0] tasq_count_type;

endpackage

// *** logic/tasq_clock_divider.sv ***
// Tick generator dividing the system clock by a selectable half period.
// Assumes half_count is at least one and comes from synchronised logic.
`timescale 1ns/1ps
module tasq_clock_divider
    import tasq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire tasq_count_type half_count,
    output logic tick
);

    tasq_count_type count_q;
    tasq_count_type count_d;
    logic at_end_w;

    assign at_end_w = (count_q >= half_count - 5'h01);
    assign count_d = at_end_w ? 5'h00 : count_q + 5'h01;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 5'h00;
            tick <= 1'h0;
        end else begin
            count_q <= count_d;
            tick <= at_end_w;
        end
    end

endmodule

// *** logic/tasq_shift_register.sv ***
// Parallel-load shift register, shifting toward the top bit.
// Assumes load and shift come from logic on the same clock.
`timescale 1ns/1ps
module tasq_shift_register #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic shift,
    input wire logic serial_in,
    input wire logic [WIDTH-1:0] par_in,
    output logic [WIDTH-1:0] par_out
);

    logic [WIDTH-1:0] par_d;

    assign par_d = load ? par_in :
                   shift ? {par_out[WIDTH-2:0], serial_in} : par_out;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            par_out <= '0;
        end else begin
            par_out <= par_d;
        end
    end

endmodule

// *** verif/tasq_converter_model.sv ***
// Behavioural serial converter that answers the sequencer's frames.
// Assumes command bits are sampled on rising and results driven on
// falling converter clock edges while chip select is low.
`timescale 1ns/1ps
module tasq_converter_model (
    input wire logic converter_clock,
    input wire logic converter_cs_n,
    input wire logic converter_din,
    output logic converter_dout
);
    logic [7:0] cmd = 8'h00;
    logic [11:0] res = 12'h000;
    int rx = 0;
    int hold = 0;
    int tx = 0;

    initial converter_dout = 1'b0;

    // A command begins at the first high bit seen while selected
    always @(posedge converter_clock) begin
        if (!converter_cs_n && (rx > 0 || converter_din)) begin
            cmd = {cmd[6:0], converter_din};
            rx = rx + 1;
        end
        if (rx == 8) begin
            rx = 0;
            res = {cmd, 4'h5};
            hold = 2;
        end
    end

    // One busy period, then the result MSB first; idle line keeps toggling
    always @(negedge converter_clock) begin
        if (hold > 0) begin
            hold = hold - 1;
            if (hold == 0) begin
                tx = 12;
            end
        end
        if (tx > 0) begin
            converter_dout = res[tx-1];
            tx = tx - 1;
        end else begin
            converter_dout = ~converter_dout;
        end
    end
endmodule

// *** verif/tb_tasq_sequencer.sv ***
// Self-checking bench for the converter sequencer.
// Assumes the converter model answers with its command byte and 4'h5.
`timescale 1ns/1ps
`include "tasq_map.svh"
module tb_tasq_sequencer;
    localparam int EXT_HALF = 8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic ext_clock_in = 1'b0;
    logic clock_source_jumper = 1'b1;
    logic divider_jumper = 1'b0;
    logic frame_length_jumper_a = 1'b1;
    logic frame_length_jumper_b = 1'b0;
    logic [7:0] command_bit_jumpers = `TASQ_CMD_DEFAULT;
    logic [7:0] command_drive_enable = 8'h00;
    logic [7:0] command_drive_value = 8'h00;
    logic irq_level_jumper = 1'b0;
    logic irq_pass_jumper = 1'b0;
    logic irq_invert_jumper = 1'b0;
    logic irq_line_in = 1'b0;
    logic irq_line_driven = 1'b0;
    logic converter_dout, converter_clock, converter_cs_n, converter_din;
    logic touch_irq_pin, word_valid_strobe;
    logic [11:0] parallel_word;
    logic ext_on = 1'b0;
    int ext_cnt = 0;
    int cycles = 0;
    int err_count = 0;
    int n_tests = 0;
    int gap;
    int hp;

    always #2 clk = ~clk;

    tasq_sequencer dut (
        .clk(clk), .reset_n(reset_n), .ext_clock_in(ext_clock_in),
        .clock_source_jumper(clock_source_jumper),
        .divider_jumper(divider_jumper),
        .frame_length_jumper_a(frame_length_jumper_a),
        .frame_length_jumper_b(frame_length_jumper_b),
        .command_bit_jumpers(command_bit_jumpers),
        .command_drive_enable(command_drive_enable),
        .command_drive_value(command_drive_value),
        .irq_level_jumper(irq_level_jumper),
        .irq_pass_jumper(irq_pass_jumper),
        .irq_invert_jumper(irq_invert_jumper),
        .irq_line_in(irq_line_in), .irq_line_driven(irq_line_driven),
        .converter_dout(converter_dout), .converter_clock(converter_clock),
        .converter_cs_n(converter_cs_n), .converter_din(converter_din),
        .touch_irq_pin(touch_irq_pin), .parallel_word(parallel_word),
        .word_valid_strobe(word_valid_strobe)
    );

    tasq_converter_model conv (
        .converter_clock(converter_clock), .converter_cs_n(converter_cs_n),
        .converter_din(converter_din), .converter_dout(converter_dout)
    );

    // External square wave, only while the external source is in use
    always @(negedge clk) begin
        if (ext_on) begin
            ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
            if (ext_cnt == EXT_HALF - 1) begin
                ext_clock_in <= ~ext_clock_in;
            end
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cycles between two changes of the converter clock
    task automatic half_period(output int n);
        logic v;
        v = converter_clock;
        n = 0;
        while (converter_clock === v && n < 100) begin
            @(negedge clk);
            n = n + 1;
        end
        v = converter_clock;
        n = 0;
        while (converter_clock === v && n < 100) begin
            @(negedge clk);
            n = n + 1;
        end
    endtask

    // Waits for the next result strobe and checks it lasts one cycle
    task automatic next_word(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (word_valid_strobe !== 1'b1 && n < 3000);
        @(negedge clk);
        check("strobe_after", 0, word_valid_strobe);
    endtask

    task automatic mode(input logic s, d, a, b, input logic [7:0] jp, en,
                        val, input int half, len, input logic [11:0] w);
        clock_source_jumper = s;
        divider_jumper = d;
        frame_length_jumper_a = a;
        frame_length_jumper_b = b;
        command_bit_jumpers = jp;
        command_drive_enable = en;
        command_drive_value = val;
        next_word(gap);
        next_word(gap);
        half_period(hp);
        check("clock_half", half, hp);
        next_word(gap);
        next_word(gap);
        check("frame_gap", 2 * half * len, gap + 1);
        check("word", w, parallel_word);
        check("select", 0, converter_cs_n);
    endtask

    initial begin
        repeat (20) @(negedge clk);
        check("select_rst", 1, converter_cs_n);
        check("strobe_rst", 0, word_valid_strobe);
        check("irq_rst", 1, touch_irq_pin);
        check("word_rst", 0, parallel_word);
        check("din_rst", 0, converter_din);
        reset_n = 1'b1;
        mode(1, 0, 1, 0, 8'h97, 8'h00, 8'h00, 5, 16, 12'h975);
        mode(1, 1, 0, 1, 8'h97, 8'h00, 8'h00, 10, 24, 12'h975);
        mode(1, 0, 0, 0, 8'hF0, 8'h0F, 8'h0A, 5, 16, 12'hFA5);
        mode(1, 1, 1, 1, 8'hC3, 8'h00, 8'h00, 10, 16, 12'hC35);
        ext_on = 1'b1;
        mode(0, 1, 0, 1, 8'h97, 8'h00, 8'h00, EXT_HALF, 24, 12'h975);
        for (int i = 0; i < 32; i++) begin
            {irq_level_jumper, irq_pass_jumper, irq_invert_jumper,
             irq_line_driven, irq_line_in} = i[4:0];
            repeat (6) @(negedge clk);
            check("irq_pin", (irq_pass_jumper & irq_line_driven) ?
                irq_line_in : (irq_invert_jumper & irq_line_driven) ?
                !irq_line_in : !irq_level_jumper, touch_irq_pin);
        end
        finish_test();
    end
endmodule
